//--- logic/dif_input_decoder.sv
// decoder of multi-function drive input terminals with an ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

module dif_input_decoder (
    input  wire logic              hclk,           // system clock
    input  wire logic              hresetn,        // async reset, active low
    input  wire logic              hsel,           // slave select
    input  wire logic [31:0]       haddr,          // byte address
    input  wire logic [1:0]        htrans,         // transfer type
    input  wire logic              hwrite,         // write when high
    input  wire logic [2:0]        hsize,          // transfer size
    input  wire logic [31:0]       hwdata,         // write data
    input  wire logic              hready,         // bus ready
    output logic [31:0]            hrdata,         // read data
    output logic                   hreadyout,      // slave ready
    output logic                   hresp,          // always okay
    input  wire dif_pkg::dif_term_t term,          // terminal inputs
    input  wire logic              drive_stopped,  // drive not running
    input  wire logic              disp_freq_zero, // displayed frequency is zero
    output dif_pkg::dif_ctl_t      ctl,            // decoded control actions
    output logic [15:0]            freq_cmd,       // up/down frequency command
    output logic [15:0]            event_count     // event counter value
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dif_pkg::dif_state_t s;
    dif_pkg::dif_state_t next_s;

    logic        addr_take;
    logic        up_edge;
    logic        down_edge;
    logic        up_step;
    logic        down_step;
    logic        hold_due;
    logic [2:0]  ramp_mode;
    logic [31:0] status_word;
    logic [31:0] rd_word;

    assign addr_take = hsel && htrans[1] && hready;
    assign up_edge   = term.freq_up && !s.prev.freq_up;
    assign down_edge = term.freq_down && !s.prev.freq_down;
    assign hold_due  = (s.hold_cnt >= s.ud_rate);
    assign up_step   = term.freq_up && !term.freq_down && (up_edge || hold_due);
    assign down_step = term.freq_down && !term.freq_up && (down_edge || hold_due);
    assign ramp_mode = s.setup[dif_pkg::CFG_RAMP_LSB +: 3];

    assign status_word = {22'h00_0000, s.ctl.freq_src, s.ctl.count_reached, s.ctl.torque_control_mode,
                          s.ctl.jog_run, s.ctl.ramp_stop, s.ctl.output_cut, s.ctl.show_base_block,
                          s.estop_lat, s.ext_lat};

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        case (haddr[7:0])
            dif_pkg::ADDR_CONFIG:  rd_word = {24'h00_0000, s.setup};
            dif_pkg::ADDR_UD_RATE: rd_word = {16'h0000, s.ud_rate};
            dif_pkg::ADDR_TARGET:  rd_word = {16'h0000, s.target};
            dif_pkg::ADDR_STATUS:  rd_word = status_word;
            dif_pkg::ADDR_FREQ:    rd_word = {16'h0000, s.freq};
            dif_pkg::ADDR_COUNT:   rd_word = {16'h0000, s.count};
            default:               rd_word = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000)
        begin
            rd_word = 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s             = s;
        next_s.hreadyout   = 1'b1;
        next_s.fault_reset = 1'b0;
        next_s.prev        = term;

        // bus: zero wait states, read data loaded from the address phase
        next_s.wr_pend = addr_take && hwrite;
        next_s.wr_addr = haddr[7:0];
        if (addr_take && !hwrite)
        begin
            next_s.hrdata = rd_word;
        end
        if (s.wr_pend)
        begin
            case (s.wr_addr)
                dif_pkg::ADDR_CONFIG:  next_s.setup       = hwdata[7:0];
                dif_pkg::ADDR_CONTROL: next_s.fault_reset = hwdata[dif_pkg::CTL_FAULT_RESET];
                dif_pkg::ADDR_UD_RATE: next_s.ud_rate     = hwdata[15:0];
                dif_pkg::ADDR_TARGET:  next_s.target      = hwdata[15:0];
                default:               next_s.setup       = s.setup;
            endcase
        end

        // fault latches: a new activation wins over a reset
        next_s.ext_lat   = term.ext_fault
                         || (s.ext_lat && !s.fault_reset);
        next_s.estop_lat = term.emergency_stop
                         || (s.estop_lat && !s.fault_reset);

        // up/down frequency command
        if (term.freq_up || term.freq_down)
        begin
            next_s.hold_cnt = (up_step || down_step) ? 16'h0001 : s.hold_cnt + 16'h0001;
        end
        else
        begin
            next_s.hold_cnt = 16'h0000;
        end
        if (up_step && s.freq != dif_pkg::FREQ_MAX)
        begin
            next_s.freq = s.freq + 16'h0001;
        end
        else if (down_step && s.freq != 16'h0000)
        begin
            next_s.freq = s.freq - 16'h0001;
        end
        if (drive_stopped && disp_freq_zero)
        begin
            next_s.freq = 16'h0000;
        end
        if (drive_stopped && s.setup[dif_pkg::CFG_NO_RETAIN])
        begin
            next_s.freq = 16'h0000;
        end

        // event counter
        if (term.count_clear)
        begin
            next_s.count = 16'h0000;
        end
        else if (term.count_pulse && !s.prev.count_pulse && s.count != 16'hFFFF)
        begin
            next_s.count = s.count + 16'h0001;
        end

        // control actions
        next_s.ctl.output_cut = term.base_block || term.output_stop
                              || next_s.estop_lat;
        next_s.ctl.coast      = term.base_block || term.output_stop
                              || next_s.estop_lat;
        next_s.ctl.ramp_stop  = next_s.ext_lat || term.force_stop;
        next_s.ctl.stop_coast = s.setup[dif_pkg::CFG_STOP_COAST];
        next_s.ctl.show_external_fault       = next_s.ext_lat;
        next_s.ctl.show_emergency_stop_fault = next_s.estop_lat;
        next_s.ctl.show_base_block           = term.base_block;
        next_s.ctl.auto_ramp = (ramp_mode >= dif_pkg::RAMP_MODE_MIN) && (ramp_mode <= dif_pkg::RAMP_MODE_MAX)
                             && !term.ramp_cancel;
        if (term.analog_force_first)
        begin
            next_s.ctl.freq_src = dif_pkg::SRC_AI1;
        end
        else if (term.analog_force_second)
        begin
            next_s.ctl.freq_src = dif_pkg::SRC_AI2;
        end
        else
        begin
            next_s.ctl.freq_src = dif_pkg::SRC_DEFAULT;
        end
        next_s.ctl.loop_bypass = term.loop_disable;
        next_s.ctl.jog_run     = s.setup[dif_pkg::CFG_RUN_SRC_TERM]
                               && (term.jog_fwd || term.jog_rev);
        next_s.ctl.jog_reverse = term.jog_rev && !term.jog_fwd;
        next_s.ctl.torque_control_mode = term.torque_select
                                       && !next_s.ctl.jog_run;
        next_s.ctl.speed_regulator_gain_b = term.gain_select;
        next_s.ctl.vf_curve_first  = s.setup[dif_pkg::CFG_VF_MODE] && term.star_conn;
        next_s.ctl.vf_curve_second = s.setup[dif_pkg::CFG_VF_MODE] && term.delta_conn
                                   && !term.star_conn;
        next_s.ctl.count_reached = (next_s.count >= s.target);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s           <= '0;
            s.hreadyout <= 1'b1;
            s.setup     <= dif_pkg::CONFIG_RST;
            s.ud_rate   <= dif_pkg::UD_RATE_RST;
            s.target    <= dif_pkg::TARGET_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign hrdata      = s.hrdata;
    assign hreadyout   = s.hreadyout;
    assign hresp       = 1'b0;
    assign ctl         = s.ctl;
    assign freq_cmd    = s.freq;
    assign event_count = s.count;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_up_edge;
        term.freq_up && !s.prev.freq_up && !term.freq_down && !drive_stopped && s.freq != dif_pkg::FREQ_MAX;
    endsequence

    sequence s_bb_effect;
        s.ctl.output_cut && s.ctl.coast && s.ctl.show_base_block;
    endsequence

    property p_ext_latch;
        @(posedge hclk) disable iff (!hresetn)
        term.ext_fault |=> s.ext_lat && s.ctl.ramp_stop ##1 (s.ext_lat || !$past(term.ext_fault));
    endproperty
    a_ext_latch: assert property (p_ext_latch) else $error("external fault not latched");

    property p_base_block;
        @(posedge hclk) disable iff (!hresetn)
        term.base_block |=> s_bb_effect;
    endproperty
    a_base_block: assert property (p_base_block) else $error("base block not applied");

    property p_out_stop;
        @(posedge hclk) disable iff (!hresetn)
        (term.output_stop && !term.base_block && !s.estop_lat && !term.emergency_stop) ##1
        (!term.output_stop && !term.base_block && !term.emergency_stop && !s.estop_lat)
        |-> s.ctl.output_cut ##1 !s.ctl.output_cut;
    endproperty
    a_out_stop: assert property (p_out_stop) else $error("output stop release wrong");

    property p_ramp_cancel;
        @(posedge hclk) disable iff (!hresetn)
        term.ramp_cancel |=> !s.ctl.auto_ramp;
    endproperty
    a_ramp_cancel: assert property (p_ramp_cancel) else $error("auto ramp not cancelled");

    property p_src_priority;
        @(posedge hclk) disable iff (!hresetn)
        term.analog_force_first && term.analog_force_second |=> s.ctl.freq_src == dif_pkg::SRC_AI1;
    endproperty
    a_src_priority: assert property (p_src_priority) else $error("analog priority wrong");

    property p_up_step;
        @(posedge hclk) disable iff (!hresetn)
        s_up_edge |=> s.freq == $past(s.freq) + 16'h0001;
    endproperty
    a_up_step: assert property (p_up_step) else $error("up step missed");

    property p_freq_zero;
        @(posedge hclk) disable iff (!hresetn)
        drive_stopped && disp_freq_zero |=> s.freq == 16'h0000;
    endproperty
    a_freq_zero: assert property (p_freq_zero) else $error("frequency not cleared");

    property p_count_clear;
        @(posedge hclk) disable iff (!hresetn)
        term.count_clear [*2] |=> s.count == 16'h0000 && event_count == 16'h0000;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("counter not held at zero");

    property p_jog_gate;
        @(posedge hclk) disable iff (!hresetn)
        !s.setup[dif_pkg::CFG_RUN_SRC_TERM] |=> !s.ctl.jog_run;
    endproperty
    a_jog_gate: assert property (p_jog_gate) else $error("jog ran without terminal source");

    property p_jog_speed;
        @(posedge hclk) disable iff (!hresetn)
        s.ctl.jog_run |-> !s.ctl.torque_control_mode;
    endproperty
    a_jog_speed: assert property (p_jog_speed) else $error("torque mode during jog");

    property p_estop;
        @(posedge hclk) disable iff (!hresetn)
        term.emergency_stop |=> s.ctl.output_cut && s.ctl.show_emergency_stop_fault
                                ##1 (s.estop_lat || !$past(term.emergency_stop) || $past(s.fault_reset));
    endproperty
    a_estop: assert property (p_estop) else $error("emergency stop not held");

    sequence s_up_held;
        term.freq_up && s.prev.freq_up && !term.freq_down && !drive_stopped && s.freq != dif_pkg::FREQ_MAX;
    endsequence

    property p_forced_stop;
        @(posedge hclk) disable iff (!hresetn)
        term.force_stop |=> s.ctl.ramp_stop && s.ctl.stop_coast == $past(s.setup[dif_pkg::CFG_STOP_COAST]);
    endproperty
    a_forced_stop: assert property (p_forced_stop) else $error("forced stop not applied");

    property p_hold_step;
        @(posedge hclk) disable iff (!hresetn)
        s_up_held ##0 (s.hold_cnt >= s.ud_rate) |=> s.freq == $past(s.freq) + 16'h0001;
    endproperty
    a_hold_step: assert property (p_hold_step) else $error("held up did not step");

    property p_hold_wait;
        @(posedge hclk) disable iff (!hresetn)
        s_up_held ##0 (s.hold_cnt < s.ud_rate) |=> s.freq == $past(s.freq);
    endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("held up stepped too soon");

    property p_no_retain;
        @(posedge hclk) disable iff (!hresetn)
        drive_stopped && s.setup[dif_pkg::CFG_NO_RETAIN] |=> s.freq == 16'h0000;
    endproperty
    a_no_retain: assert property (p_no_retain) else $error("frequency retained");

    property p_levels;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> s.ctl.loop_bypass == $past(term.loop_disable) && s.ctl.speed_regulator_gain_b == $past(term.gain_select);
    endproperty
    a_levels: assert property (p_levels) else $error("bypass or gain select wrong");

    property p_count_step;
        @(posedge hclk) disable iff (!hresetn)
        term.count_pulse && !s.prev.count_pulse && !term.count_clear && s.count != 16'hFFFF
        |=> s.count == $past(s.count) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter pulse missed");

    property p_vf_curves;
        @(posedge hclk) disable iff (!hresetn)
        !s.setup[dif_pkg::CFG_VF_MODE] |=> !s.ctl.vf_curve_first && !s.ctl.vf_curve_second;
    endproperty
    a_vf_curves: assert property (p_vf_curves) else $error("curve chosen outside v/f");

endmodule : dif_input_decoder

//--- logic/dif_pkg.sv
// shared constants and types of the drive input function decoder
package dif_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CONFIG   = 8'h00;
    localparam logic [7:0]  ADDR_CONTROL  = 8'h04;
    localparam logic [7:0]  ADDR_UD_RATE  = 8'h08;
    localparam logic [7:0]  ADDR_TARGET   = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS   = 8'h10;
    localparam logic [7:0]  ADDR_FREQ     = 8'h14;
    localparam logic [7:0]  ADDR_COUNT    = 8'h18;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CFG_RUN_SRC_TERM = 0;
    localparam int CFG_VF_MODE      = 1;
    localparam int CFG_RAMP_LSB     = 2;
    localparam int CFG_STOP_COAST   = 5;
    localparam int CFG_NO_RETAIN    = 7;
    localparam int CTL_FAULT_RESET  = 0;

    // ----------------------------------------------------------------
    // reset values and limits
    // ----------------------------------------------------------------
    localparam logic [7:0]  CONFIG_RST    = 8'h00;
    localparam logic [15:0] UD_RATE_RST   = 16'h0100;
    localparam logic [15:0] TARGET_RST    = 16'hFFFF;
    localparam logic [15:0] FREQ_MAX      = 16'hFFFF;
    localparam logic [2:0]  RAMP_MODE_MIN = 3'h1;
    localparam logic [2:0]  RAMP_MODE_MAX = 3'h4;

    // frequency source select
    localparam logic [1:0]  SRC_DEFAULT   = 2'h0;
    localparam logic [1:0]  SRC_AI1       = 2'h1;
    localparam logic [1:0]  SRC_AI2       = 2'h2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ext_fault;
        logic base_block;
        logic output_stop;
        logic ramp_cancel;
        logic analog_force_first;
        logic analog_force_second;
        logic force_stop;
        logic freq_up;
        logic freq_down;
        logic loop_disable;
        logic count_clear;
        logic count_pulse;
        logic jog_fwd;
        logic jog_rev;
        logic torque_select;
        logic gain_select;
        logic emergency_stop;
        logic star_conn;
        logic delta_conn;
    } dif_term_t;

    typedef struct packed {
        logic       output_cut;
        logic       coast;
        logic       ramp_stop;
        logic       stop_coast;
        logic       show_external_fault;
        logic       show_emergency_stop_fault;
        logic       show_base_block;
        logic       auto_ramp;
        logic [1:0] freq_src;
        logic       loop_bypass;
        logic       jog_run;
        logic       jog_reverse;
        logic       torque_control_mode;
        logic       speed_regulator_gain_b;
        logic       vf_curve_first;
        logic       vf_curve_second;
        logic       count_reached;
    } dif_ctl_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [7:0]  setup;
        logic [15:0] ud_rate;
        logic [15:0] target;
        logic        fault_reset;
        dif_term_t   prev;
        logic        ext_lat;
        logic        estop_lat;
        logic [15:0] freq;
        logic [15:0] hold_cnt;
        logic [15:0] count;
        dif_ctl_t    ctl;
    } dif_state_t;

endpackage : dif_pkg

//--- testbench/dif_field_switches.sv
// field switch contacts driving the drive's input terminals
`timescale 1ns/1ps

module dif_field_switches (
    input  wire logic               hclk, // system clock
    input  wire dif_pkg::dif_term_t want, // contact positions asked for
    output dif_pkg::dif_term_t      term  // terminal levels seen by the drive
);
    // contacts settle one cycle after being thrown
    always_ff @(posedge hclk)
    begin
        term <= want;
    end
endmodule : dif_field_switches

//--- testbench/testbench.sv
// self-checking bench of the drive input function decoder
`timescale 1ns/1ps

module testbench;
    logic               hclk;
    logic               hresetn;
    logic               hsel;
    logic [31:0]        haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic [31:0]        hwdata;
    logic [31:0]        hrdata;
    logic               hreadyout;
    logic               hresp;
    logic               drive_stopped;
    logic               disp_freq_zero;
    logic [15:0]        freq_cmd;
    logic [15:0]        event_count;
    logic [31:0]        rd;
    dif_pkg::dif_term_t want;
    dif_pkg::dif_term_t term;
    dif_pkg::dif_ctl_t  ctl;
    int                 errors;
    int                 check_count;
    int                 cycles;

    dif_field_switches sw (.hclk(hclk), .want(want), .term(term));
    dif_input_decoder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .term(term), .drive_stopped(drive_stopped),
        .disp_freq_zero(disp_freq_zero), .ctl(ctl), .freq_cmd(freq_cmd), .event_count(event_count));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task step(input int n);
        repeat (n) @(posedge hclk);
    endtask : step

    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hwdata <= ~hwdata;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    // one activation: 0 up, 1 down, 2 counter pulse
    task pulse(input int which);
        case (which)
            0: want.freq_up <= 1'b1;
            1: want.freq_down <= 1'b1;
            default: want.count_pulse <= 1'b1;
        endcase
        step(2);
        want.freq_up     <= 1'b0;
        want.freq_down   <= 1'b0;
        want.count_pulse <= 1'b0;
        step(3);
    endtask : pulse

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        ahb(1'b0, dif_pkg::ADDR_UD_RATE, 32'h0000_0000);
        check("ud_rate reset", rd, 32'h0000_0100);
        ahb(1'b0, dif_pkg::ADDR_TARGET, 32'h0000_0000);
        check("target reset", rd, 32'h0000_FFFF);
        ahb(1'b0, 8'h1C, 32'h0000_0000);
        check("unmapped read", rd, 32'h0000_0000);
        check("hresp okay", hresp, 32'h0000_0000);
    endtask : t_regs

    task t_faults;
        want.ext_fault <= 1'b1;
        step(3);
        check("ext fault", {ctl.ramp_stop, ctl.show_external_fault}, 32'h0000_0003);
        ahb(1'b1, dif_pkg::ADDR_CONTROL, 32'h0000_0001);
        want.ext_fault <= 1'b0;
        step(3);
        ahb(1'b0, dif_pkg::ADDR_STATUS, 32'h0000_0000);
        check("ext fault held", rd[0], 32'h0000_0001);
        ahb(1'b1, dif_pkg::ADDR_CONTROL, 32'h0000_0001);
        step(3);
        check("ext fault cleared", ctl.show_external_fault, 32'h0000_0000);
        want.emergency_stop <= 1'b1;
        step(3);
        want.emergency_stop <= 1'b0;
        step(3);
        check("estop held", {ctl.output_cut, ctl.coast, ctl.show_emergency_stop_fault}, 32'h0000_0007);
        ahb(1'b1, dif_pkg::ADDR_CONTROL, 32'h0000_0001);
        step(3);
        check("estop cleared", ctl.show_emergency_stop_fault, 32'h0000_0000);
    endtask : t_faults

    task t_levels;
        want.base_block <= 1'b1;
        step(3);
        check("base block", {ctl.output_cut, ctl.coast, ctl.show_base_block}, 32'h0000_0007);
        want.base_block  <= 1'b0;
        want.output_stop <= 1'b1;
        step(3);
        check("output stop", ctl.output_cut, 32'h0000_0001);
        want.output_stop <= 1'b0;
        step(3);
        check("output restart", ctl.output_cut, 32'h0000_0000);
        ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'h0000_0020);
        want.force_stop   <= 1'b1;
        want.loop_disable <= 1'b1;
        want.gain_select  <= 1'b1;
        step(3);
        check("forced stop", {ctl.ramp_stop, ctl.stop_coast}, 32'h0000_0003);
        check("loop bypass", ctl.loop_bypass, 32'h0000_0001);
        check("gain b", ctl.speed_regulator_gain_b, 32'h0000_0001);
        want.force_stop   <= 1'b0;
        want.loop_disable <= 1'b0;
        want.gain_select  <= 1'b0;
        step(3);
        check("levels off", {ctl.ramp_stop, ctl.loop_bypass, ctl.speed_regulator_gain_b}, 32'h0000_0000);
    endtask : t_levels

    task t_source;
        for (int i = 0; i < 4; i++)
        begin
            want.analog_force_first  <= i[0];
            want.analog_force_second <= i[1];
            step(3);
            check("freq source", ctl.freq_src, i[0] ? dif_pkg::SRC_AI1 : i[1] ? dif_pkg::SRC_AI2 :
                dif_pkg::SRC_DEFAULT);
        end
        want.analog_force_first  <= 1'b0;
        want.analog_force_second <= 1'b0;
    endtask : t_source

    task t_ramp;
        for (int m = 0; m < 8; m++)
        begin
            ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'(m) << 2);
            want.ramp_cancel <= m[0];
            step(3);
            check("auto ramp", ctl.auto_ramp, 32'((m >= 1 && m <= 4) && !m[0]));
        end
        want.ramp_cancel <= 1'b0;
        ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'h0000_0000);
    endtask : t_ramp

    task t_updown;
        logic [15:0] f0;
        ahb(1'b1, dif_pkg::ADDR_UD_RATE, 32'h0000_0004);
        pulse(0);
        pulse(0);
        check("up steps", freq_cmd, 32'h0000_0002);
        pulse(1);
        check("down step", freq_cmd, 32'h0000_0001);
        f0 = freq_cmd;
        want.freq_up <= 1'b1;
        step(40);
        want.freq_up <= 1'b0;
        step(3);
        check("held up rate", 32'(freq_cmd >= f0 + 8 && freq_cmd <= f0 + 12), 32'h0000_0001);
        drive_stopped <= 1'b1;
        step(3);
        check("kept while stopped", 32'(freq_cmd > 0), 32'h0000_0001);
        disp_freq_zero <= 1'b1;
        step(3);
        check("zero when stopped", freq_cmd, 32'h0000_0000);
        drive_stopped  <= 1'b0;
        disp_freq_zero <= 1'b0;
        pulse(0);
        ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'h0000_0080);
        drive_stopped <= 1'b1;
        step(3);
        check("not retained", freq_cmd, 32'h0000_0000);
        drive_stopped <= 1'b0;
        ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'h0000_0000);
    endtask : t_updown

    task t_counter;
        ahb(1'b1, dif_pkg::ADDR_TARGET, 32'h0000_0003);
        for (int i = 0; i < 3; i++) pulse(2);
        check("count", event_count, 32'h0000_0003);
        check("target reached", ctl.count_reached, 32'h0000_0001);
        want.count_clear <= 1'b1;
        step(3);
        pulse(2);
        check("held clear", event_count, 32'h0000_0000);
        want.count_clear <= 1'b0;
        step(3);
        pulse(2);
        check("count resumes", event_count, 32'h0000_0001);
    endtask : t_counter

    task t_jog;
        want.jog_fwd <= 1'b1;
        step(3);
        check("jog refused", ctl.jog_run, 32'h0000_0000);
        want.jog_fwd       <= 1'b0;
        want.torque_select <= 1'b1;
        ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'h0000_0001);
        step(3);
        check("torque mode", ctl.torque_control_mode, 32'h0000_0001);
        want.jog_rev <= 1'b1;
        step(3);
        check("jog reverse", {ctl.jog_run, ctl.jog_reverse, ctl.torque_control_mode}, 32'h0000_0006);
        want.jog_rev <= 1'b0;
        step(3);
        check("jog done", {ctl.jog_run, ctl.torque_control_mode}, 32'h0000_0001);
        want.torque_select <= 1'b0;
        step(3);
        check("speed mode", ctl.torque_control_mode, 32'h0000_0000);
    endtask : t_jog

    task t_curves;
        ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'h0000_0002);
        want.star_conn <= 1'b1;
        step(3);
        check("star curve", {ctl.vf_curve_first, ctl.vf_curve_second}, 32'h0000_0002);
        want.star_conn  <= 1'b0;
        want.delta_conn <= 1'b1;
        step(3);
        check("delta curve", {ctl.vf_curve_first, ctl.vf_curve_second}, 32'h0000_0001);
        ahb(1'b1, dif_pkg::ADDR_CONFIG, 32'h0000_0000);
        step(3);
        check("no v/f curve", ctl.vf_curve_second, 32'h0000_0000);
    endtask : t_curves

    // ----------------------------------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        {hsel, haddr, htrans, hwrite, hwdata, drive_stopped, disp_freq_zero} = '0;
        hsize   = 3'h2;
        want    = '0;
        hresetn = 1'b0;
        errors  = 0;
        check_count = 0;
        cycles  = 0;
        step(12);
        hresetn <= 1'b1;
        t_regs();
        t_faults();
        t_levels();
        t_source();
        t_ramp();
        t_updown();
        t_counter();
        t_jog();
        t_curves();
        tally_and_finish();
    end
endmodule : testbench
